// ---- rtl/sram_host.sv ----
// Host controller that runs read and write cycles on a byte-wide asynchronous static memory with error flag.
`timescale 1ns/100ps
`default_nettype none
module sram_host (
  input  wire logic                                core_clk_i,
  input  wire logic                                rst_i,
  input  wire logic                                req_valid_i,
  input  wire sram_host_pkg::mem_req_t             req_i,
  output logic                                     req_ready_o,
  output logic                                     resp_valid_o,
  output sram_host_pkg::mem_resp_t                 resp_o,
  output sram_host_pkg::pin_out_t                  pins_o,
  input  wire logic [sram_host_pkg::DATA_W-1:0]    data_i,
  output logic      [sram_host_pkg::DATA_W-1:0]    data_o,
  output logic                                     data_oe_n_o,
  input  wire logic                                err_i
);
  import sram_host_pkg::*;

  // Counter loads are one less than the cycle counts because the zero cycle is the last one.
  localparam logic [CNT_W-1:0] READ_LOAD    = CNT_W'(READ_WAIT_CYC - 1);
  localparam logic [CNT_W-1:0] PULSE_LOAD   = CNT_W'(PULSE_CYC - 1);
  localparam logic [CNT_W-1:0] RECOVER_LOAD = CNT_W'(RECOVER_CYC - 1);

  host_state_t            state_q;
  host_state_t            state_d;
  logic [CNT_W-1:0]       cnt_q;
  logic [CNT_W-1:0]       cnt_d;
  pin_out_t               pins_q;
  pin_out_t               pins_d;
  logic [DATA_W-1:0]      wdata_q;
  logic [DATA_W-1:0]      wdata_d;
  logic                   data_oe_n_q;
  logic                   data_oe_n_d;
  logic                   resp_valid_q;
  logic                   resp_valid_d;
  mem_resp_t              resp_q;
  mem_resp_t              resp_d;
  logic [DATA_W:0]        back_sync;

  // One-hot state test shared by the accept, ready and completion decodes.
  function automatic logic in_state(input host_state_t cur, input host_state_t want);
    in_state = (cur == want);
  endfunction : in_state

  // Reads may chain from the last wait cycle; a write starts only from idle.
  wire in_idle    = in_state(state_q, ST_IDLE);
  wire in_read    = in_state(state_q, ST_READ);
  wire cnt_done   = (cnt_q == '0);
  wire read_done  = in_read && cnt_done;
  wire pulse_done = in_state(state_q, ST_WPULSE) && cnt_done;
  wire write_done = in_state(state_q, ST_WHOLD) && cnt_done;
  wire can_accept = in_idle || read_done;
  wire take       = req_valid_i && can_accept;
  wire take_read  = take && !req_i.write;
  wire take_write = take && req_i.write && in_idle;

  // A write behind a read waits for idle, so output enable is high a cycle before the host drives.
  assign req_ready_o = in_idle || (read_done && !req_i.write);

  // Data and error flag share one synchroniser so both come from the same memory cycle.
  sram_pin_sync #(
    .WIDTH (DATA_W + 1)
  ) u_back_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    ({err_i, data_i}),
    .sync_o     (back_sync)
  );

  // Every register except the counter holds unless a state moves it; the completion pulse defaults low.
  always_comb begin
    state_d      = state_q;
    cnt_d        = cnt_q;
    pins_d       = pins_q;
    wdata_d      = wdata_q;
    data_oe_n_d  = data_oe_n_q;
    resp_valid_d = 1'b0;
    resp_d       = resp_q;
    // The counter runs down by itself and rests at zero; states only reload it.
    if (!cnt_done) begin
      cnt_d = cnt_q - CNT_W'(1);
    end
    case (state_q)
      ST_IDLE: begin
        if (take_read) begin
          state_d                 = ST_READ;
          cnt_d                   = READ_LOAD;
          pins_d.addr             = req_i.addr;
          pins_d.primary_select_n = 1'b0;
          pins_d.secondary_select = 1'b1;
          pins_d.write_n          = 1'b1;
          pins_d.output_enable_n  = 1'b0;
        end else if (take_write) begin
          // Output enable stays high so the memory floats before the host drives the bus.
          state_d                 = ST_WSETUP;
          pins_d.addr             = req_i.addr;
          pins_d.primary_select_n = 1'b0;
          pins_d.secondary_select = 1'b1;
          pins_d.write_n          = 1'b1;
          pins_d.output_enable_n  = 1'b1;
          wdata_d                 = req_i.wdata;
          data_oe_n_d             = 1'b0;
        end
      end
      ST_READ: begin
        if (cnt_done) begin
          // Data and flag are sampled together after the address delay and the synchroniser.
          resp_valid_d = 1'b1;
          resp_d.write = 1'b0;
          resp_d.rdata = back_sync[DATA_W-1:0];
          resp_d.err   = back_sync[DATA_W];
          if (take_read) begin
            cnt_d       = READ_LOAD;
            pins_d.addr = req_i.addr;
          end else begin
            state_d                 = ST_IDLE;
            pins_d.primary_select_n = RST_PRIMARY_SELECT_N;
            pins_d.secondary_select = RST_SECONDARY_SELECT;
            pins_d.output_enable_n  = RST_OUTPUT_ENABLE_N;
          end
        end
      end
      ST_WSETUP: begin
        state_d        = ST_WPULSE;
        cnt_d          = PULSE_LOAD;
        pins_d.write_n = 1'b0;
      end
      ST_WPULSE: begin
        // One pulse cycle covers the float delay plus the data setup at this clock rate.
        if (pulse_done) begin
          state_d        = ST_WHOLD;
          cnt_d          = RECOVER_LOAD;
          pins_d.write_n = 1'b1;
        end
      end
      ST_WHOLD: begin
        if (write_done) begin
          // Data is released only after the strobe that ended the write has risen.
          state_d                 = ST_IDLE;
          data_oe_n_d             = RST_DATA_OE_N;
          pins_d.primary_select_n = RST_PRIMARY_SELECT_N;
          pins_d.secondary_select = RST_SECONDARY_SELECT;
          resp_valid_d            = 1'b1;
          resp_d.write            = 1'b1;
          resp_d.err              = 1'b0;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pins_q.addr             <= '0;
      pins_q.primary_select_n <= RST_PRIMARY_SELECT_N;
      pins_q.secondary_select <= RST_SECONDARY_SELECT;
      pins_q.write_n          <= RST_WRITE_N;
      pins_q.output_enable_n  <= RST_OUTPUT_ENABLE_N;
    end else begin
      pins_q <= pins_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wdata_q     <= '0;
      data_oe_n_q <= RST_DATA_OE_N;
    end else begin
      wdata_q     <= wdata_d;
      data_oe_n_q <= data_oe_n_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      resp_valid_q <= 1'b0;
      resp_q       <= '0;
    end else begin
      resp_valid_q <= resp_valid_d;
      resp_q       <= resp_d;
    end
  end

  // Every pin leaves straight from a flip-flop so no glitch reaches the memory strobes.
  assign pins_o       = pins_q;
  assign data_o       = wdata_q;
  assign data_oe_n_o  = data_oe_n_q;
  assign resp_valid_o = resp_valid_q;
  assign resp_o       = resp_q;

endmodule : sram_host
`default_nettype wire

// ---- rtl/sram_host_pkg.sv ----
// Package with pin layouts, request carriers, states and timing counts for the static memory host.
package sram_host_pkg;

  localparam int ADDR_W   = 21;
  localparam int DATA_W   = 8;
  localparam int SYNC_LEN = 2;

  // Timing figures in nanoseconds for the slower speed grade, and the clock period.
  localparam int CLK_PERIOD_NS          = 50;
  localparam int ADDRESS_TO_VALID_DELAY = 55;
  localparam int WRITE_PULSE_NS         = 40;
  localparam int FLOAT_AFTER_WRITE_DELAY = 20;
  localparam int DATA_SETUP_TO_END      = 25;
  localparam int CYCLE_TIME_NS          = 55;

  // Least times round up to whole cycles and never fall below one.
  localparam int READ_VALID_CYC = (ADDRESS_TO_VALID_DELAY + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_WAIT_CYC  = READ_VALID_CYC + SYNC_LEN;
  localparam int PULSE_MIN_NS   = (WRITE_PULSE_NS > FLOAT_AFTER_WRITE_DELAY + DATA_SETUP_TO_END) ?
                                  WRITE_PULSE_NS : FLOAT_AFTER_WRITE_DELAY + DATA_SETUP_TO_END;
  localparam int PULSE_CYC      = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_RAW    = (CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - PULSE_CYC;
  localparam int RECOVER_CYC    = (RECOVER_RAW < 1) ? 1 : RECOVER_RAW;

  localparam int CNT_W = 4;

  // Values of the pins after reset: deselected, no strobe, outputs disabled.
  localparam logic RST_PRIMARY_SELECT_N = 1'b1;
  localparam logic RST_SECONDARY_SELECT = 1'b0;
  localparam logic RST_WRITE_N          = 1'b1;
  localparam logic RST_OUTPUT_ENABLE_N  = 1'b1;
  localparam logic RST_DATA_OE_N        = 1'b1;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              primary_select_n;
    logic              secondary_select;
    logic              write_n;
    logic              output_enable_n;
  } pin_out_t;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic              write;
    logic [DATA_W-1:0] rdata;
    logic              err;
  } mem_resp_t;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_READ   = 5'h02,
    ST_WSETUP = 5'h04,
    ST_WPULSE = 5'h08,
    ST_WHOLD  = 5'h10
  } host_state_t;

endpackage : sram_host_pkg

// ---- rtl/sram_pin_sync.sv ----
// Two-stage synchroniser for the bus inputs that come back from the memory pins.
`timescale 1ns/100ps
`default_nettype none
module sram_pin_sync #(
  parameter int WIDTH = 9
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : sram_pin_sync
`default_nettype wire

// ---- tb/sram_host_assertions.sv ----
// Checker with the pin and handshake properties of the static memory host.
`timescale 1ns/100ps
`default_nettype none
module sram_host_assertions (
  input wire logic                     core_clk_i,
  input wire logic                     rst_i,
  input wire logic                     req_valid_i,
  input wire sram_host_pkg::mem_req_t  req_i,
  input wire logic                     req_ready_o,
  input wire logic                     resp_valid_o,
  input wire sram_host_pkg::mem_resp_t resp_o,
  input wire sram_host_pkg::pin_out_t  pins_o,
  input wire logic [7:0]               data_o,
  input wire logic                     data_oe_n_o
);
  import sram_host_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire take_rd = req_valid_i && req_ready_o && !req_i.write;
  wire take_wr = req_valid_i && req_ready_o && req_i.write;
  property p_sel_pair; pins_o.primary_select_n == !pins_o.secondary_select; endproperty
  a_sel_pair: assert property (p_sel_pair) else $error("selects disagree");
  property p_read_we; !pins_o.output_enable_n |-> pins_o.write_n; endproperty
  a_read_we: assert property (p_read_we) else $error("strobe low in read");
  property p_no_clash; !data_oe_n_o |-> pins_o.output_enable_n; endproperty
  a_no_clash: assert property (p_no_clash) else $error("bus contention");
  property p_wr_sel; !pins_o.write_n |-> !pins_o.primary_select_n && !data_oe_n_o; endproperty
  a_wr_sel: assert property (p_wr_sel) else $error("strobe outside write");
  property p_pulse; $fell(pins_o.write_n) |=> pins_o.write_n && !pins_o.primary_select_n; endproperty
  a_pulse: assert property (p_pulse) else $error("bad write pulse");
  property p_hold; $rose(pins_o.write_n) |-> $stable(data_o) && !data_oe_n_o; endproperty
  a_hold: assert property (p_hold) else $error("data not held");
  property p_rd_resp; take_rd |-> ##5 resp_valid_o && !resp_o.write; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  property p_wr_resp; take_wr |-> ##4 resp_valid_o && resp_o.write; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  property p_wr_err; resp_valid_o && resp_o.write |-> !resp_o.err; endproperty
  a_wr_err: assert property (p_wr_err) else $error("error on write");
endmodule : sram_host_assertions
bind sram_host sram_host_assertions u_chk (.core_clk_i, .rst_i, .req_valid_i, .req_i, .req_ready_o,
  .resp_valid_o, .resp_o, .pins_o, .data_o, .data_oe_n_o);
`default_nettype wire

// ---- tb/sram_mem_model.sv ----
// Behavioural model of the byte-wide static memory with corrected-error flag.
`timescale 1ns/100ps
`default_nettype none
module sram_mem_model (
  input  wire sram_host_pkg::pin_out_t pins_i,
  input  wire logic [7:0]              bus_i,
  input  wire logic                    inject_i,
  output var logic [7:0]               rd_o,
  output var logic                     err_o
);
  import sram_host_pkg::*;
  logic [7:0]        mem [logic [ADDR_W-1:0]];
  logic              errf [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] a_d;
  wire sel = !pins_i.primary_select_n && pins_i.secondary_select;
  wire wr  = sel && !pins_i.write_n;
  wire rd  = sel && pins_i.write_n && !pins_i.output_enable_n;
  assign #(ADDRESS_TO_VALID_DELAY) a_d = pins_i.addr;
  initial begin
    rd_o = 8'h00;
    err_o = 1'b0;
  end
  // A marked write keeps the good byte but flags it as corrected on later reads until the next write there.
  always @(negedge wr) begin
    mem[pins_i.addr] = bus_i;
    errf[pins_i.addr] = inject_i;
  end
  // Outside a valid read both outputs flip so a stale value never looks valid.
  always @(rd or a_d or pins_i.addr) begin
    if (rd && a_d === pins_i.addr && mem.exists(a_d)) begin
      rd_o = mem[a_d];
      err_o = errf[a_d];
    end else begin
      rd_o = ~rd_o;
      err_o = ~err_o;
    end
  end
endmodule : sram_mem_model
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking testbench for the static memory host.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import sram_host_pkg::*;
  logic core_clk_i, rst_i, req_valid_i, inject, ready, rv, oe_n, err;
  mem_req_t   req_i;
  mem_resp_t  resp, got_q[$];
  pin_out_t   pins;
  logic [7:0] host_d, mem_d, bus;
  int fail_count = 0;
  int n_compared = 0;
  assign bus = (oe_n === 1'b0) ? host_d : mem_d;
  sram_host u_dut (.core_clk_i, .rst_i, .req_valid_i, .req_i, .req_ready_o(ready), .resp_valid_o(rv),
    .resp_o(resp), .pins_o(pins), .data_i(bus), .data_o(host_d), .data_oe_n_o(oe_n), .err_i(err));
  sram_mem_model u_mem (.pins_i(pins), .bus_i(bus), .inject_i(inject), .rd_o(mem_d), .err_o(err));
  initial begin
    core_clk_i = 1'b0;
    forever #(CLK_PERIOD_NS / 2) core_clk_i = ~core_clk_i;
  end
  always @(negedge core_clk_i) if (rv === 1'b1) got_q.push_back(resp);
  task automatic chk(input logic [26:0] e, input logic [26:0] g);
    n_compared++;
    if (e !== g) begin
      fail_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic send(input logic w, input logic [20:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    req_valid_i = 1'b1;
    req_i = '{w, a, d};
    #1;
    while (ready !== 1'b1) begin
      @(negedge core_clk_i);
      #1;
    end
    @(posedge core_clk_i);
  endtask : send
  task automatic drain(input int n);
    @(negedge core_clk_i);
    req_valid_i = 1'b0;
    repeat (60) if (got_q.size() < n) @(posedge core_clk_i);
    chk(27'(n), 27'(got_q.size()));
  endtask : drain
  task automatic t_reset;
    chk({pins, oe_n, rv}, {21'h0, 4'hB, 2'h2});
    chk(27'({ready, resp, host_d}), 27'h0040000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_mid_reset;
    send(1'b0, 21'h000123, 8'h00);
    @(negedge core_clk_i);
    req_valid_i = 1'b0;
    rst_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    chk({pins, oe_n, rv}, {21'h0, 4'hB, 2'h2});
    chk(27'(ready), 27'h1);
    rst_i = 1'b0;
    got_q.delete();
    send(1'b0, 21'h000123, 8'h00);
    drain(1);
    if (got_q.size() > 0) chk(27'(got_q[0]), 27'h078);
    got_q.delete();
    $display("test mid_reset done");
  endtask : t_mid_reset
  task automatic t_write_read;
    for (int i = 0; i < 4; i++) send(1'b1, 21'(i * 21'h0AAAAA), 8'h5A ^ 8'(i));
    for (int i = 0; i < 4; i++) send(1'b0, 21'(i * 21'h0AAAAA), 8'h00);
    drain(8);
    for (int i = 0; i < 8; i++) begin
      if (got_q.size() > i) chk(27'(got_q[i]), 27'({i < 4, i < 4 ? 8'h00 : 8'h5A ^ 8'(i - 4), 1'b0}));
    end
    got_q.delete();
    $display("test write_read done");
  endtask : t_write_read
  task automatic t_err;
    inject = 1'b1;
    send(1'b1, 21'h000123, 8'hC3);
    drain(1);
    inject = 1'b0;
    send(1'b0, 21'h000123, 8'h00);
    send(1'b0, 21'h000123, 8'h00);
    send(1'b1, 21'h000123, 8'h3C);
    send(1'b0, 21'h000123, 8'h00);
    drain(5);
    for (int i = 1; i < 3; i++) if (got_q.size() > i) chk(27'(got_q[i]), 27'h187);
    if (got_q.size() > 4) chk(27'(got_q[4]), 27'h078);
    got_q.delete();
    $display("test err done");
  endtask : t_err
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  initial begin
    rst_i = 1'b1;
    req_valid_i = 1'b0;
    req_i = '0;
    inject = 1'b0;
    repeat (8) @(negedge core_clk_i);
    t_reset();
    rst_i = 1'b0;
    t_write_read();
    t_err();
    t_mid_reset();
    finish_test();
  end
  initial begin
    repeat (3000) @(posedge core_clk_i);
    fail_count++;
    finish_test();
  end
endmodule : tb
`default_nettype wire
